// *** logic/cbt_pkg.sv ***
// package for the 250 kbit/s bit timing block: timing constants, register map, carrier structs
package cbt_pkg;
  // ---------------------------------------------------------------
  // clock and bit timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000; // mclk_i period, 125 MHz
  localparam int TQ_PS = 250000; // time quantum, 250 ns
  localparam int TQ_CYCLES = TQ_PS / CLK_PERIOD_PS; // 31 whole clocks per quantum
  localparam int TQ_LONG_INDEX = 3; // quanta 3, 7, 11 and 15 of a bit get one clock more
  localparam int SYNC_TQ = 1; // synchronisation quantum
  localparam int PRE_SAMPLE_TQ = 12; // pre_sample_phase length
  localparam int POST_SAMPLE_TQ = 3; // post_sample_phase length
  localparam int RJW_TQ = 2; // resync_jump_width
  localparam int BIT_TQ = SYNC_TQ + PRE_SAMPLE_TQ + POST_SAMPLE_TQ; // 16 quanta
  localparam int BIT_PERIOD_PS = 4000000; // nominal bit time, 4 us
  localparam int BIT_CYCLES = BIT_PERIOD_PS / CLK_PERIOD_PS; // 500 clocks per bit
  localparam int SAMPLE_PCT = 80; // nominal sample point, percent of the bit
  localparam int SAMPLE_TOL_PCT = 3; // sample point tolerance, percent
  localparam int SAMPLE_MIN_CYCLES = BIT_CYCLES * (SAMPLE_PCT - SAMPLE_TOL_PCT) / 100; // earliest sample
  localparam int SAMPLE_MAX_CYCLES = BIT_CYCLES * (SAMPLE_PCT + SAMPLE_TOL_PCT) / 100; // latest sample
  localparam int AVAIL_MIN_PS = 2750000; // least available propagation time
  localparam int AVAIL_MIN_CYCLES = AVAIL_MIN_PS / CLK_PERIOD_PS; // same, in clocks
  localparam int AVAIL_PS = (SYNC_TQ + PRE_SAMPLE_TQ - RJW_TQ) * TQ_PS; // 11 quanta from bit start, 2.75 us
  // ---------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL_ADDR = 4'h0; // control
  localparam logic [3:0] REG_STATUS_ADDR = 4'h4; // status
  localparam logic [3:0] REG_TXBIT_ADDR = 4'h8; // transmit level
  localparam logic [3:0] REG_BITCNT_ADDR = 4'hc; // sampled-bit counter
  localparam int CTRL_ENABLE_BIT = 0; // enable bit timing
  localparam int TX_DOMINANT_BIT = 0; // 1 = drive dominant
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000; // control reset value
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000; // read data for unmapped address

  // bit phase states, one-hot
  typedef enum logic [2:0] {
    CBT_SYNC = 3'h1,
    CBT_PRE = 3'h2,
    CBT_POST = 3'h4
  } cbt_phase_t;

  // avalon request carrier
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } cbt_av_req_t;

  // avalon answer carrier
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } cbt_av_rsp_t;
endpackage

// *** logic/cbt_bit_timing.sv ***
// bit timing, sampling and wired-dominant bus logic for a 250 kbit/s node
// ---------------------------------------------------------------
// Functional notes
// [RULE_01] nominal bit period four microseconds, 250 kbit/s
// [RULE_02] bit period within 3.998 to 4.002 us
// [RULE_03] timing derived from crystal-accurate mclk_i
// [RULE_04] synchronise only on recessive-to-dominant edges
// [RULE_05] sample bus exactly once per bit
// [RULE_06] sample point at eighty percent of bit
// [RULE_07] 250 ns quantum, 12/3 phases, jump 2
// [RULE_08] propagation time is pre-sample minus jump width
// [RULE_09] any enabled transmitter makes bus dominant
// [RULE_10] release driver for recessive bits
// [RULE_11] comparator output gives single dominant/recessive bit
// [RULE_12] present recessive level while idle
// [RULE_13] sync, pre-sample, post-sample: sixteen quanta total
// ---------------------------------------------------------------
module cbt_bit_timing (
  input wire logic mclk_i, // 125 MHz crystal clock
  input wire logic reset_i, // synchronous active-high reset
  input wire cbt_pkg::cbt_av_req_t av_req_i, // avalon request
  output cbt_pkg::cbt_av_rsp_t av_rsp_o, // avalon answer
  input wire logic rx_dominant_i, // comparator output, 1 = dominant
  output logic tx_dominant_o, // 1 = transmitter on (dominant)
  output logic sample_o, // one-cycle pulse at sample point
  output logic rx_bit_o // last sampled bit, 1 = dominant
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic enable_reg; // bit timing enabled
  logic tx_dom_reg; // software's transmit level
  logic [15:0] bitcnt_reg; // sampled bits since enable
  logic [4:0] tq_cnt_reg; // cycles inside current quantum
  logic [4:0] seg_cnt_reg; // quanta inside current phase
  logic [4:0] post_len_reg; // post-sample length after resync
  logic [4:0] pre_len_reg; // pre-sample length after resync
  cbt_pkg::cbt_phase_t phase_reg; // current bit phase
  logic rx_prev_reg; // bus level one cycle ago
  logic synced_reg; // edge already used in this bit
  logic sample_reg; // sample strobe
  logic rx_bit_reg; // sampled level
  logic ack_reg; // waitrequest low one cycle
  logic [31:0] rdata_reg; // read data
  logic tx_out_reg; // registered driver output
  logic tq_end; // last cycle of a quantum
  logic fall_edge; // recessive-to-dominant edge
  logic av_access; // request pending and not answered
  logic [4:0] tq_index; // quantum number inside the bit
  logic tq_long; // this quantum runs one clock longer
  logic new_bit; // first cycle of a bit opened by the sequencer
  cbt_pkg::cbt_phase_t phase_prev_reg; // phase one cycle ago, check helper
  logic [9:0] bit_len_reg; // clocks since the bit began, check helper
  logic bit_moved_reg; // an edge may have moved this bit, check helper
  logic bit_full_reg; // one whole bit measured since enable

  // decodes one register address
  function automatic logic addr_is(input logic [3:0] a, input logic [3:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  // ---------------------------------------------------------------
  // fractional quantum: 31.25 clocks on average
  // ---------------------------------------------------------------
  // 250 ns is no whole number of 8 ns clocks, so every fourth quantum of a bit
  // runs one clock longer; sixteen quanta then last exactly 500 clocks, 4 us
  assign tq_index = (phase_reg == cbt_pkg::CBT_PRE) ? seg_cnt_reg + 5'(cbt_pkg::SYNC_TQ)
    : (phase_reg == cbt_pkg::CBT_POST) ? seg_cnt_reg + 5'(cbt_pkg::SYNC_TQ + cbt_pkg::PRE_SAMPLE_TQ) : 5'h00;
  assign tq_long = (tq_index[1:0] == 2'(cbt_pkg::TQ_LONG_INDEX)); // [RULE_02]

  // long quantum ends one count later; the average stays at 250 ns
  assign tq_end = (tq_cnt_reg == (tq_long ? 5'(cbt_pkg::TQ_CYCLES) : 5'(cbt_pkg::TQ_CYCLES - 1))); // [RULE_02] [RULE_07]
  assign fall_edge = rx_dominant_i && !rx_prev_reg; // [RULE_04] [RULE_11]
  assign av_access = (av_req_i.read || av_req_i.write) && !ack_reg;

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle, answer on the second edge
  // ---------------------------------------------------------------
  // ack pulses for a single cycle so each request completes exactly once
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= av_access;
    end
  end

  // register writes take effect at the accepting edge
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      enable_reg <= cbt_pkg::CTRL_RESET[cbt_pkg::CTRL_ENABLE_BIT];
      tx_dom_reg <= 1'b0; // [RULE_12]
    end else if (av_req_i.write && ack_reg) begin
      if (addr_is(av_req_i.address, cbt_pkg::REG_CTRL_ADDR)) begin
        enable_reg <= av_req_i.writedata[cbt_pkg::CTRL_ENABLE_BIT];
      end else if (addr_is(av_req_i.address, cbt_pkg::REG_TXBIT_ADDR)) begin
        tx_dom_reg <= av_req_i.writedata[cbt_pkg::TX_DOMINANT_BIT];
      end
    end
  end

  // read data prepared in the wait cycle, valid while waitrequest is low
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (av_access) begin
      if (addr_is(av_req_i.address, cbt_pkg::REG_CTRL_ADDR)) begin
        rdata_reg <= {31'h0000_0000, enable_reg};
      end else if (addr_is(av_req_i.address, cbt_pkg::REG_STATUS_ADDR)) begin
        rdata_reg <= {28'h000_0000, phase_reg, rx_bit_reg};
      end else if (addr_is(av_req_i.address, cbt_pkg::REG_TXBIT_ADDR)) begin
        rdata_reg <= {31'h0000_0000, tx_dom_reg};
      end else if (addr_is(av_req_i.address, cbt_pkg::REG_BITCNT_ADDR)) begin
        rdata_reg <= {16'h0000, bitcnt_reg};
      end else begin
        rdata_reg <= cbt_pkg::UNMAPPED_DATA; // unmapped reads zero
      end
    end
  end

  assign av_rsp_o.waitrequest = !ack_reg;
  assign av_rsp_o.readdata = rdata_reg;

  // ---------------------------------------------------------------
  // bus edge history
  // ---------------------------------------------------------------
  // comparator level is already synchronous, one register gives the edge
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rx_prev_reg <= 1'b0;
    end else begin
      rx_prev_reg <= rx_dominant_i;
    end
  end

  // ---------------------------------------------------------------
  // quantum prescaler, from the crystal clock
  // ---------------------------------------------------------------
  // counts 31 clocks, or 32 in a long quantum; an unused edge outside the pre-sample phase restarts it,
  // a dominant-to-recessive edge never does
  always_ff @(posedge mclk_i) begin
    if (reset_i || !enable_reg) begin
      tq_cnt_reg <= 5'h00;
    end else if (tq_end || (fall_edge && phase_reg != cbt_pkg::CBT_PRE && !synced_reg)) begin
      tq_cnt_reg <= 5'h00; // [RULE_03] [RULE_04]
    end else begin
      tq_cnt_reg <= tq_cnt_reg + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // phase sequencer with hard and soft synchronisation
  // ---------------------------------------------------------------
  // only recessive-to-dominant edges restart or stretch the bit
  always_ff @(posedge mclk_i) begin
    if (reset_i || !enable_reg) begin
      phase_reg <= cbt_pkg::CBT_SYNC;
      seg_cnt_reg <= 5'h00;
      synced_reg <= 1'b0;
      pre_len_reg <= 5'(cbt_pkg::PRE_SAMPLE_TQ);
      post_len_reg <= 5'(cbt_pkg::POST_SAMPLE_TQ);
    end else if (fall_edge && !synced_reg && phase_reg == cbt_pkg::CBT_POST) begin
      // early edge in post phase: shorten, bounded by the jump width
      synced_reg <= 1'b1; // [RULE_04]
      if (5'(cbt_pkg::POST_SAMPLE_TQ) - seg_cnt_reg <= 5'(cbt_pkg::RJW_TQ)) begin
        phase_reg <= cbt_pkg::CBT_PRE; // [RULE_13]
        seg_cnt_reg <= 5'h00;
        pre_len_reg <= 5'(cbt_pkg::PRE_SAMPLE_TQ);
      end else begin
        post_len_reg <= seg_cnt_reg + 5'(cbt_pkg::POST_SAMPLE_TQ) - 5'(cbt_pkg::RJW_TQ);
      end
    end else if (fall_edge && !synced_reg && phase_reg == cbt_pkg::CBT_PRE) begin
      // late edge: lengthen pre phase by at most the jump width
      synced_reg <= 1'b1; // [RULE_04] [RULE_08]
      pre_len_reg <= 5'(cbt_pkg::PRE_SAMPLE_TQ)
        + ((seg_cnt_reg < 5'(cbt_pkg::RJW_TQ)) ? seg_cnt_reg + 5'h01 : 5'(cbt_pkg::RJW_TQ));
    end else if (tq_end) begin
      case (phase_reg)
        cbt_pkg::CBT_SYNC: begin
          phase_reg <= cbt_pkg::CBT_PRE; // [RULE_13]
          seg_cnt_reg <= 5'h00;
          synced_reg <= 1'b0;
        end
        cbt_pkg::CBT_PRE: begin
          if (seg_cnt_reg == pre_len_reg - 5'h01) begin
            phase_reg <= cbt_pkg::CBT_POST; // [RULE_06] [RULE_13]
            seg_cnt_reg <= 5'h00;
            pre_len_reg <= 5'(cbt_pkg::PRE_SAMPLE_TQ);
          end else begin
            seg_cnt_reg <= seg_cnt_reg + 5'h01;
          end
        end
        cbt_pkg::CBT_POST: begin
          if (seg_cnt_reg == post_len_reg - 5'h01) begin
            phase_reg <= cbt_pkg::CBT_SYNC; // [RULE_01] [RULE_13]
            seg_cnt_reg <= 5'h00;
            post_len_reg <= 5'(cbt_pkg::POST_SAMPLE_TQ);
            synced_reg <= 1'b0;
          end else begin
            seg_cnt_reg <= seg_cnt_reg + 5'h01;
          end
        end
        default: begin
          phase_reg <= cbt_pkg::CBT_SYNC;
          seg_cnt_reg <= 5'h00;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // single sample point at the end of the pre-sample phase
  // ---------------------------------------------------------------
  // one sample per bit; no majority vote, so no extra filter delay
  always_ff @(posedge mclk_i) begin
    if (reset_i || !enable_reg) begin
      sample_reg <= 1'b0;
      rx_bit_reg <= 1'b0;
      bitcnt_reg <= 16'h0000;
    end else if (tq_end && phase_reg == cbt_pkg::CBT_PRE && seg_cnt_reg == pre_len_reg - 5'h01) begin
      sample_reg <= 1'b1; // [RULE_05] [RULE_06]
      rx_bit_reg <= rx_dominant_i; // [RULE_11]
      bitcnt_reg <= bitcnt_reg + 16'h0001;
    end else begin
      sample_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // transmitter: on only for dominant, released otherwise
  // ---------------------------------------------------------------
  // the bus wires dominant over recessive, so recessive means switched off
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tx_out_reg <= 1'b0; // [RULE_12]
    end else begin
      tx_out_reg <= enable_reg && tx_dom_reg; // [RULE_09] [RULE_10] [RULE_12]
    end
  end

  assign tx_dominant_o = tx_out_reg;
  assign sample_o = sample_reg;
  assign rx_bit_o = rx_bit_reg;

  // ---------------------------------------------------------------
  // check helpers: bit length measured between bit starts
  // ---------------------------------------------------------------
  assign new_bit = (phase_reg == cbt_pkg::CBT_SYNC) && (phase_prev_reg == cbt_pkg::CBT_POST);

  // previous phase marks the post-to-sync step that opens a bit
  always_ff @(posedge mclk_i) begin
    if (reset_i || !enable_reg) begin
      phase_prev_reg <= cbt_pkg::CBT_SYNC;
    end else begin
      phase_prev_reg <= phase_reg;
    end
  end

  // clocks since the bit began, held at its top so it never wraps
  always_ff @(posedge mclk_i) begin
    if (reset_i || !enable_reg) begin
      bit_len_reg <= 10'h000;
    end else if (new_bit) begin
      bit_len_reg <= 10'h001;
    end else if (bit_len_reg != 10'h3ff) begin
      bit_len_reg <= bit_len_reg + 10'h001;
    end
  end

  // any recessive-to-dominant edge marks the bit; conservative, ignored edges count too
  always_ff @(posedge mclk_i) begin
    if (reset_i || !enable_reg) begin
      bit_moved_reg <= 1'b0;
      bit_full_reg <= 1'b0;
    end else if (new_bit) begin
      bit_moved_reg <= fall_edge;
      bit_full_reg <= 1'b1;
    end else if (fall_edge) begin
      bit_moved_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_sample_seen;
    sample_reg ##1 !sample_reg;
  endsequence

  chk_single_sample: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_05]
    s_sample_seen |-> !sample_reg [*8])
    else $error("two samples too close");

  chk_sample_phase: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_06]
    sample_reg |-> phase_reg == cbt_pkg::CBT_POST)
    else $error("sample outside pre to post boundary");

  chk_tx_release: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_10]
    !tx_dom_reg |=> !tx_out_reg)
    else $error("driver not released for recessive");

  chk_tx_dominant: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_09]
    (tx_dom_reg && enable_reg) |=> tx_out_reg)
    else $error("dominant not driven");

  chk_idle_recessive: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_12]
    !enable_reg |=> !tx_out_reg)
    else $error("driver on while idle");

  chk_no_rise_sync: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_04]
    (enable_reg && !rx_dominant_i && rx_prev_reg && !tq_end)
      |=> tq_cnt_reg == $past(tq_cnt_reg) + 5'h01)
    else $error("resync on dominant-to-recessive edge");

  chk_sync_to_pre: assert property (@(posedge mclk_i) disable iff (reset_i || !enable_reg) // [RULE_13]
    (phase_reg == cbt_pkg::CBT_SYNC && tq_end) |=> phase_reg == cbt_pkg::CBT_PRE)
    else $error("sync quantum not followed by pre-sample phase");

  chk_quantum_len: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_07]
    tq_cnt_reg <= (tq_long ? 5'(cbt_pkg::TQ_CYCLES) : 5'(cbt_pkg::TQ_CYCLES - 1)))
    else $error("quantum counter overran");

  chk_bus_answer: assert property (@(posedge mclk_i) disable iff (reset_i)
    ((av_req_i.read || av_req_i.write) && !ack_reg) |=> !av_rsp_o.waitrequest)
    else $error("bus answer late");

  sequence s_bit_opens;
    new_bit && bit_full_reg && !bit_moved_reg;
  endsequence

  chk_bit_period: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_01] [RULE_02]
    s_bit_opens |-> bit_len_reg == 10'(cbt_pkg::BIT_CYCLES))
    else $error("undisturbed bit not 500 clocks long");

  chk_sample_point: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_06]
    (sample_reg && !bit_moved_reg) |->
      (bit_len_reg >= 10'(cbt_pkg::SAMPLE_MIN_CYCLES)) && (bit_len_reg <= 10'(cbt_pkg::SAMPLE_MAX_CYCLES)))
    else $error("sample point outside its window");

  chk_avail_time: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_08]
    (sample_reg && !bit_moved_reg) |-> bit_len_reg >= 10'(cbt_pkg::AVAIL_MIN_CYCLES + cbt_pkg::RJW_TQ * cbt_pkg::TQ_CYCLES))
    else $error("available propagation time too short");

  chk_sample_bit: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_11]
    sample_reg |-> rx_bit_reg == $past(rx_dominant_i))
    else $error("sampled bit differs from comparator level");

  chk_pre_len_bound: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_07] [RULE_08]
    (pre_len_reg >= 5'(cbt_pkg::PRE_SAMPLE_TQ)) && (pre_len_reg <= 5'(cbt_pkg::PRE_SAMPLE_TQ + cbt_pkg::RJW_TQ)))
    else $error("pre-sample phase stretched beyond jump width");
endmodule // cbt_bit_timing

// *** tb/cbt_ecu_model.sv ***
// behavioural model of another node on the shared bus that sends one bit pattern
module cbt_ecu_model (
  input wire logic mclk_i, // node clock
  input wire logic reset_i, // synchronous reset, active high
  input wire logic start_i, // one-cycle pulse starts a frame
  input wire logic [7:0] pattern_i, // bits to send, msb first, 1 = dominant
  output logic bus_dom_o // 1 = this node's transmitter on
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // bit clock of the far node
  // ---------------------------------------------------------------
  localparam int BIT_CYC = cbt_pkg::BIT_PERIOD_PS / cbt_pkg::CLK_PERIOD_PS; // 500 clocks per bit
  logic [8:0] cyc_reg; // clocks into the current bit
  logic [3:0] idx_reg; // bit index in the frame
  logic busy_reg; // frame in progress
  logic [7:0] pat_reg; // latched pattern
  // frame sequencer: exact 4 us bits, the same length as the device's own bit
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      busy_reg <= 1'b0;
      cyc_reg <= 9'h000;
      idx_reg <= 4'h0;
      pat_reg <= 8'h00;
    end else if (start_i) begin
      busy_reg <= 1'b1;
      cyc_reg <= 9'h000;
      idx_reg <= 4'h0;
      pat_reg <= pattern_i;
    end else if (busy_reg) begin
      if (cyc_reg == 9'(BIT_CYC - 1)) begin
        cyc_reg <= 9'h000;
        idx_reg <= idx_reg + 4'h1;
        busy_reg <= (idx_reg != 4'h7);
      end else begin
        cyc_reg <= cyc_reg + 9'h001;
      end
    end
  end
  // driver released outside frames and for recessive bits
  assign bus_dom_o = busy_reg && pat_reg[3'h7 - idx_reg[2:0]];
endmodule // cbt_ecu_model

// *** tb/test_can_bit_timing_250k.sv ***
// self-checking testbench for the bit timing block with one far node on the bus
module test_can_bit_timing_250k;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic mclk_i; // 125 MHz clock
  logic reset_i; // synchronous reset
  cbt_pkg::cbt_av_req_t av_req; // register bus request
  cbt_pkg::cbt_av_rsp_t av_rsp; // register bus answer
  logic tx_dom; // device transmitter
  logic sample; // sample point pulse
  logic rx_bit; // last sampled bit
  logic far_dom; // far node transmitter
  logic start; // far node frame start
  logic bus; // wired-dominant bus level
  logic bus_q, smp_q; // previous bus level and sample pulse
  logic [31:0] d; // read data
  int cyc, rise_cyc, bad_count, num_checks; // cycle count, edge time, tallies
  int t_q[$]; // cycles of sample pulses
  logic b_q[$]; // sampled bits
  localparam logic [7:0] PAT = 8'h30; // rec rec dom dom rec...
  assign bus = tx_dom | far_dom; // any enabled transmitter wins
  cbt_bit_timing u_cbt_bit_timing (.mclk_i(mclk_i), .reset_i(reset_i), .av_req_i(av_req), .av_rsp_o(av_rsp),
    .rx_dominant_i(bus), .tx_dominant_o(tx_dom), .sample_o(sample), .rx_bit_o(rx_bit));
  cbt_ecu_model u_cbt_ecu_model (.mclk_i(mclk_i), .reset_i(reset_i), .start_i(start), .pattern_i(PAT),
    .bus_dom_o(far_dom));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // closing report, the only place the run ends
  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // compare with four-state equality so an unknown seen never matches a known expected value
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // one register access; held until waitrequest is sampled low
  task automatic av_access(input logic rd, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge mclk_i);
    av_req <= '{read: rd, write: !rd, address: a, writedata: wd};
    do begin
      @(posedge mclk_i);
      n++;
    end while (av_rsp.waitrequest !== 1'b0 && n < 100);
    rdat = av_rsp.readdata;
    av_req <= '0;
    if (n >= 100) begin
      bad_count++;
      print_verdict();
    end
  endtask
  // ---------------------------------------------------------------
  // clock, monitor and watchdog
  // ---------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  // log bus edges, sample times and the bit seen one cycle after each sample
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    bus_q <= bus;
    smp_q <= (sample === 1'b1);
    if (bus === 1'b1 && bus_q === 1'b0) rise_cyc <= cyc;
    if (sample === 1'b1) t_q.push_back(cyc);
    if (smp_q) b_q.push_back(rx_bit);
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge mclk_i);
    bad_count++;
    print_verdict();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    av_req = '0;
    start = 1'b0;
    cyc = 0;
    bad_count = 0;
    num_checks = 0;
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    chk("tx after reset", tx_dom, 32'h0);
    av_access(1'b1, cbt_pkg::REG_CTRL_ADDR, 32'h0, d);
    chk("ctrl reset", d, cbt_pkg::CTRL_RESET);
    av_access(1'b1, 4'h2, 32'h0, d);
    chk("unmapped read", d, cbt_pkg::UNMAPPED_DATA);
    // a dominant request while disabled must leave the bus recessive
    av_access(1'b0, cbt_pkg::REG_TXBIT_ADDR, 32'h1, d);
    av_access(1'b1, cbt_pkg::REG_TXBIT_ADDR, 32'h0, d);
    chk("txbit readback", d, 32'h1);
    repeat (600) @(posedge mclk_i);
    chk("tx while disabled", tx_dom, 32'h0);
    chk("samples while disabled", t_q.size(), 32'h0);
    av_access(1'b0, cbt_pkg::REG_TXBIT_ADDR, 32'h0, d);
    // enable and start the far frame nearly aligned
    av_access(1'b0, cbt_pkg::REG_CTRL_ADDR, 32'h1, d);
    start <= 1'b1;
    @(posedge mclk_i);
    start <= 1'b0;
    for (int i = 0; i < 4000 && t_q.size() < 7; i++) @(posedge mclk_i);
    if (t_q.size() < 7) begin
      bad_count++;
      print_verdict();
    end
    chk("bit period", t_q[1] - t_q[0], cbt_pkg::BIT_CYCLES);
    chk("period at falling edge", t_q[4] - t_q[3], cbt_pkg::BIT_CYCLES);
    chk("period after falling edge", t_q[5] - t_q[4], cbt_pkg::BIT_CYCLES);
    // 77 to 83 percent of a 500-clock bit after the resynchronising edge
    chk("sample point", (t_q[2] - rise_cyc >= cbt_pkg::SAMPLE_MIN_CYCLES)
      && (t_q[2] - rise_cyc <= cbt_pkg::SAMPLE_MAX_CYCLES), 32'h1);
    for (int i = 0; i < 6; i++) chk("sampled bit", b_q[i], PAT[7 - i]);
    av_access(1'b1, cbt_pkg::REG_BITCNT_ADDR, 32'h0, d);
    chk("bit counter", d[15:0], t_q.size());
    av_access(1'b1, cbt_pkg::REG_STATUS_ADDR, 32'h0, d);
    chk("status bit", d[0], b_q[b_q.size() - 1]);
    chk("status phase", $onehot(d[3:1]), 32'h1);
    av_access(1'b1, cbt_pkg::REG_CTRL_ADDR, 32'h0, d);
    chk("ctrl readback", d, 32'h1);
    // transmitter on wins the wired bus, off releases it
    av_access(1'b0, cbt_pkg::REG_TXBIT_ADDR, 32'h1, d);
    repeat (2) @(posedge mclk_i);
    chk("tx dominant", tx_dom, 32'h1);
    chk("bus dominant", bus, 32'h1);
    av_access(1'b0, cbt_pkg::REG_TXBIT_ADDR, 32'h0, d);
    repeat (2) @(posedge mclk_i);
    chk("tx released", tx_dom, 32'h0);
    av_access(1'b0, cbt_pkg::REG_TXBIT_ADDR, 32'h1, d);
    av_access(1'b0, cbt_pkg::REG_CTRL_ADDR, 32'h0, d);
    repeat (2) @(posedge mclk_i);
    chk("tx idle after disable", tx_dom, 32'h0);
    print_verdict();
  end
endmodule // test_can_bit_timing_250k
